/* hw/llp_pkg.sv */
// Shared types, codes and helpers for the linked pair checker
package llp_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 64;
  localparam int REG_W = 5;
  localparam int WORD_W = 32;

  // ----------------------------------------
  // Access sizes and alignment masks
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] WORD_BYTES = 64'h0000_0000_0000_0004;
  localparam logic [ADDR_W-1:0] DWORD_BYTES = 64'h0000_0000_0000_0008;
  localparam logic [3:0] WORD_NAT_MASK = 4'h3;
  localparam logic [3:0] DWORD_NAT_MASK = 4'h7;
  localparam logic [3:0] WORD_PAIR_MASK = 4'h7;
  localparam logic [3:0] DWORD_PAIR_MASK = 4'hf;

  // ----------------------------------------
  // Exception cause codes
  // ----------------------------------------
  localparam logic [3:0] EXC_NONE = 4'h0;
  localparam logic [3:0] EXC_RSVD_INSTR = 4'h1;
  localparam logic [3:0] EXC_ADDR_ERR = 4'h2;
  localparam logic [3:0] EXC_BREAK = 4'h3;
  localparam logic [3:0] EXC_DEBUG_BRK = 4'h4;
  localparam logic [3:0] EXC_SSTEP = 4'h5;
  localparam logic [3:0] EXC_INTR = 4'h6;
  localparam logic [3:0] EXC_EXT_ALONE = 4'h7;

  // ----------------------------------------
  // Decoded operation classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_LL_WORD,
    OP_LL_DWORD,
    OP_LL_WORD_ALT,
    OP_SC_WORD,
    OP_SC_DWORD,
    OP_SC_WORD_ALT,
    OP_BREAK,
    OP_DEBUG_BRK
  } llp_op_e;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EVAL
  } llp_state_e;

  typedef struct packed {
    logic isExt;
    llp_op_e op;
    logic [REG_W-1:0] base;
    logic [REG_W-1:0] target;
    logic [WORD_W-1:0] word;
  } llp_instr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] branchPc;
    logic inDelaySlot;
    logic inForbiddenSlot;
    llp_instr_s extInstr;
    llp_instr_s nextInstr;
    logic [ADDR_W-1:0] extVaddr;
    logic [ADDR_W-1:0] plainVaddr;
    logic [ADDR_W-1:0] plainPaddr;
    logic extAloneFault;
    logic interruptPending;
    logic singleStep;
  } llp_req_s;

  typedef struct packed {
    logic valid;
    logic excValid;
    logic [3:0] cause;
    logic [ADDR_W-1:0] retPc;
    logic delaySlot;
    logic debugExc;
    logic priorWe;
    logic [WORD_W-1:0] priorInstr;
    logic pairIsLoad;
    logic pairIsStore;
    logic memIssue;
    logic memDouble;
    logic wrExtTarget;
    logic wrPlainTarget;
    logic storeCommit;
    logic storeCancel;
  } llp_resp_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic isLoadOp(input llp_op_e op);
    return op == OP_LL_WORD || op == OP_LL_DWORD || op == OP_LL_WORD_ALT;
  endfunction : isLoadOp

  function automatic logic isStoreOp(input llp_op_e op);
    return op == OP_SC_WORD || op == OP_SC_DWORD || op == OP_SC_WORD_ALT;
  endfunction : isStoreOp

  function automatic logic isDwordOp(input llp_op_e op);
    return op == OP_LL_DWORD || op == OP_SC_DWORD;
  endfunction : isDwordOp

endpackage : llp_pkg

/* hw/llp_align_chk.sv */
// Alignment and adjacency checks for an extended pair
`timescale 1ns/1ps
module llp_align_chk
  import llp_pkg::*;
(
  // Access width and pair addresses
  input wire logic isDword,
  input wire logic [ADDR_W-1:0] extVaddr,
  input wire logic [ADDR_W-1:0] plainVaddr,
  input wire logic [ADDR_W-1:0] plainPaddr,
  // Results
  output logic natMisalign,
  output logic dblMisalign,
  output logic notLowest
);

  logic [3:0] natMask;
  logic [3:0] pairMask;
  logic [ADDR_W-1:0] size;

  always_comb begin
    natMask = isDword ? DWORD_NAT_MASK : WORD_NAT_MASK;
    pairMask = isDword ? DWORD_PAIR_MASK : WORD_PAIR_MASK;
    size = isDword ? DWORD_BYTES : WORD_BYTES;
    natMisalign = (extVaddr[3:0] & natMask) != 4'h0;
    dblMisalign = ((plainVaddr[3:0] & pairMask) != 4'h0) || ((plainPaddr[3:0] & pairMask) != 4'h0);
    notLowest = (plainVaddr + size) != extVaddr;
  end

endmodule : llp_align_chk

/* hw/llp_pair_checker.sv */
// Exception checker for extended linked load and conditional store pairs
// Function
// RULE1: Next-instruction fault sets flag, captures extended word
// RULE2: Extended op in slot: reserved, branch PC
// RULE3: Unmatched next instruction: reserved, flag set
// RULE4: Breakpoint after extended op beats reserved
// RULE5: Differing base fields: reserved, flag set
// RULE6: Load base equals target: reserved, flag clear
// RULE7: Software keeps offsets apart by data size
// RULE8: Natural misalignment: address error, flag clear
// RULE9: Pair double aligned, plain at lower address
// RULE10: Double alignment checked virtual and physical
// RULE11: Extended-alone faults reported before pair faults
// RULE12: Single step at extended op, pair atomic
// RULE13: Store pair fault cancels, keeps link flag
// RULE14: Handler resumes at extended store
// RULE15: Load pair fault: no access, no writes
// RULE16: Handler resumes at extended load
// RULE17: Mismatched sequence type fails conditional store
// RULE18: Load pair single or split access
// RULE19: Trap after extended load makes store fail
// RULE20: Plain instruction must hit lowest address
// RULE21: Link flag clear on load pair fault
// RULE22: Checks decoded before any pair access
`timescale 1ns/1ps
module llp_pair_checker
  import llp_pkg::*;
#(
  parameter bit SINGLE_ACCESS = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Request
  input wire logic reqValid,
  input wire llp_req_s req,
  output logic reqReady,
  // Result
  output llp_resp_s resp,
  output logic linkValidFlag
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    llp_state_e st;
    llp_req_s q;
    llp_resp_s resp;
    logic linkValid;
    llp_op_e linkOp;
    logic ready;
  } llp_core_s;

  llp_core_s state_reg;
  llp_core_s state_next;

  logic natMisalign;
  logic dblMisalign;
  logic notLowest;
  logic inSlot;
  logic extIsLoad;
  logic extIsStore;
  logic plainMatch;
  logic bd0Hit;

  // ----------------------------------------
  // Address checks
  // ----------------------------------------
  llp_align_chk u_align (
    .isDword(isDwordOp(state_reg.q.extInstr.op)),
    .extVaddr(state_reg.q.extVaddr),
    .plainVaddr(state_reg.q.plainVaddr),
    .plainPaddr(state_reg.q.plainPaddr),
    .natMisalign(natMisalign),
    .dblMisalign(dblMisalign),
    .notLowest(notLowest)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.resp = '0;
    inSlot = state_reg.q.inDelaySlot || state_reg.q.inForbiddenSlot;
    extIsLoad = isLoadOp(state_reg.q.extInstr.op);
    extIsStore = isStoreOp(state_reg.q.extInstr.op);
    plainMatch = !state_reg.q.nextInstr.isExt && state_reg.q.nextInstr.op == state_reg.q.extInstr.op;
    bd0Hit = inSlot || state_reg.q.extAloneFault || (extIsLoad &&
      state_reg.q.extInstr.base == state_reg.q.extInstr.target) || natMisalign || state_reg.q.interruptPending;
    case (state_reg.st)
      ST_IDLE: begin
        if (reqValid) begin
          state_next.q = req;
          state_next.st = ST_EVAL;
          state_next.ready = 1'b0;
        end
      end
      ST_EVAL: begin
        // Decoded fields of both words are judged here, before any access
        state_next.resp.valid = 1'b1; // see RULE22
        state_next.resp.pairIsLoad = extIsLoad;
        state_next.resp.pairIsStore = extIsStore;
        state_next.resp.excValid = 1'b1;
        state_next.resp.retPc = state_reg.q.pc; // see RULE14, RULE16
        state_next.resp.delaySlot = 1'b1;
        state_next.resp.priorInstr = state_reg.q.extInstr.word;
        if (inSlot) begin
          state_next.resp.cause = EXC_RSVD_INSTR; // see RULE2
          state_next.resp.retPc = state_reg.q.branchPc; // see RULE2
        end else if (state_reg.q.extAloneFault) begin
          state_next.resp.cause = EXC_EXT_ALONE; // see RULE11
          state_next.resp.delaySlot = 1'b0;
        end else if (extIsLoad && state_reg.q.extInstr.base == state_reg.q.extInstr.target) begin
          state_next.resp.cause = EXC_RSVD_INSTR; // see RULE6
          state_next.resp.delaySlot = 1'b0;
        end else if (natMisalign) begin
          state_next.resp.cause = EXC_ADDR_ERR; // see RULE8
          state_next.resp.delaySlot = 1'b0;
        end else if (state_reg.q.interruptPending) begin
          state_next.resp.cause = EXC_INTR; // see RULE13
          state_next.resp.delaySlot = 1'b0;
        end else if (state_reg.q.nextInstr.op == OP_BREAK) begin
          state_next.resp.cause = EXC_BREAK; // see RULE4
          state_next.resp.priorWe = 1'b1; // see RULE1
        end else if (state_reg.q.nextInstr.op == OP_DEBUG_BRK) begin
          state_next.resp.cause = EXC_DEBUG_BRK; // see RULE4
          state_next.resp.debugExc = 1'b1;
          state_next.resp.priorWe = 1'b1; // see RULE1
        end else if (!plainMatch) begin
          state_next.resp.cause = EXC_RSVD_INSTR; // see RULE3
          state_next.resp.priorWe = 1'b1; // see RULE1
        end else if (state_reg.q.nextInstr.base != state_reg.q.extInstr.base) begin
          state_next.resp.cause = EXC_RSVD_INSTR; // see RULE5
          state_next.resp.priorWe = 1'b1; // see RULE1
        end else if (dblMisalign || notLowest) begin
          state_next.resp.cause = EXC_ADDR_ERR; // see RULE9, RULE10, RULE20
          state_next.resp.priorWe = 1'b1; // see RULE1
        end else begin
          state_next.resp.excValid = 1'b0;
          state_next.resp.cause = EXC_NONE;
          state_next.resp.delaySlot = 1'b0;
          if (extIsLoad) begin
            state_next.resp.memIssue = 1'b1;
            state_next.resp.memDouble = SINGLE_ACCESS; // see RULE18
            state_next.resp.wrExtTarget = 1'b1;
            state_next.resp.wrPlainTarget = 1'b1;
            state_next.linkValid = 1'b1;
            state_next.linkOp = state_reg.q.extInstr.op;
          end else if (extIsStore) begin
            // A store after a different pair type is failed
            state_next.resp.memIssue = state_reg.linkValid && state_reg.linkOp ==
              (state_reg.q.extInstr.op == OP_SC_WORD ? OP_LL_WORD :
               state_reg.q.extInstr.op == OP_SC_DWORD ? OP_LL_DWORD : OP_LL_WORD_ALT); // see RULE17, RULE19
            state_next.resp.storeCommit = state_next.resp.memIssue;
            state_next.linkValid = 1'b0;
          end
          if (state_reg.q.singleStep) begin
            // One step covers the whole pair
            state_next.resp.excValid = 1'b1;
            state_next.resp.cause = EXC_SSTEP; // see RULE12
            state_next.resp.debugExc = 1'b1;
          end
        end
        if (state_next.resp.excValid && state_next.resp.cause != EXC_SSTEP) begin
          if (extIsLoad) begin
            state_next.linkValid = 1'b0; // see RULE15, RULE21
          end
          state_next.resp.storeCancel = extIsStore; // see RULE13
        end
        state_next.st = ST_IDLE;
        state_next.ready = 1'b1;
      end
      default: begin
        state_next.st = ST_IDLE;
        state_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '{st: ST_IDLE, q: '0, resp: '0, linkValid: 1'b0, linkOp: OP_OTHER, ready: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reqReady = state_reg.ready;
  assign resp = state_reg.resp;
  assign linkValidFlag = state_reg.linkValid;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic evalPair;
  logic pairStage;

  assign evalPair = state_reg.st == ST_EVAL && (extIsLoad || extIsStore);
  assign pairStage = evalPair && !bd0Hit && plainMatch && state_reg.q.nextInstr.base == state_reg.q.extInstr.base;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_slot_reserved: assert property ((state_reg.st == ST_EVAL && inSlot) |=> // see RULE2
    resp.excValid && resp.cause == EXC_RSVD_INSTR && resp.delaySlot && resp.retPc == $past(state_reg.q.branchPc))
    else $error("slot placement not reported as reserved instruction");

  a_base_target: assert property ((state_reg.st == ST_EVAL && !inSlot && !state_reg.q.extAloneFault && extIsLoad // see RULE6
    && state_reg.q.extInstr.base == state_reg.q.extInstr.target) |=> resp.cause == EXC_RSVD_INSTR && !resp.delaySlot)
    else $error("base equal target not reported with flag clear");

  a_natural_align: assert property ((state_reg.st == ST_EVAL && natMisalign) |=> // see RULE8
    resp.excValid && !resp.memIssue && (resp.cause == EXC_ADDR_ERR || resp.cause == EXC_RSVD_INSTR ||
    resp.cause == EXC_EXT_ALONE))
    else $error("misaligned extended access not faulted");

  a_brk_priority: assert property ((state_reg.st == ST_EVAL && !bd0Hit && state_reg.q.nextInstr.op == OP_BREAK) // see RULE4
    |=> resp.cause == EXC_BREAK && resp.delaySlot && resp.priorWe && resp.priorInstr == $past(state_reg.q.extInstr.word))
    else $error("breakpoint after extended op mis-reported");

  a_mismatch_ri: assert property ((state_reg.st == ST_EVAL && !bd0Hit && !plainMatch && // see RULE3
    state_reg.q.nextInstr.op != OP_BREAK && state_reg.q.nextInstr.op != OP_DEBUG_BRK)
    |=> resp.cause == EXC_RSVD_INSTR && resp.delaySlot && resp.retPc == $past(state_reg.q.pc))
    else $error("unmatched next instruction not reserved");

  a_bd0_first: assert property ((state_reg.st == ST_EVAL && !inSlot && bd0Hit) |=> // see RULE11
    resp.excValid && !resp.delaySlot && !resp.priorWe)
    else $error("extended-alone fault reported with flag set");

  a_load_fault: assert property ((resp.valid && resp.excValid && resp.pairIsLoad && resp.cause != EXC_SSTEP) // see RULE15
    |-> !linkValidFlag && !resp.memIssue && !resp.wrExtTarget && !resp.wrPlainTarget)
    else $error("load pair fault had side effects");

  a_store_keep: assert property ((state_reg.st == ST_EVAL && extIsStore && bd0Hit) |=> // see RULE13
    resp.storeCancel && !resp.storeCommit && linkValidFlag == $past(state_reg.linkValid))
    else $error("store pair fault changed link flag");

  a_sstep_atomic: assert property ((resp.cause == EXC_SSTEP) |-> // see RULE12
    !resp.delaySlot && resp.debugExc && $past(state_reg.st) == ST_EVAL && resp.retPc == $past(state_reg.q.pc))
    else $error("single step reported wrongly");

  a_resp_pulse: assert property (resp.valid |=> !resp.valid) // see RULE22
    else $error("result held longer than one cycle");

  a_base_differ: assert property ((evalPair && !bd0Hit && plainMatch && !pairStage) |=> // see RULE5
    resp.cause == EXC_RSVD_INSTR && resp.delaySlot && resp.priorWe)
    else $error("differing base fields not reserved");

  a_prior_capture: assert property (resp.priorWe |-> // see RULE1
    resp.excValid && resp.delaySlot && resp.priorInstr == $past(state_reg.q.extInstr.word))
    else $error("prior instruction capture wrong");

  a_dbg_priority: assert property ((evalPair && !bd0Hit && state_reg.q.nextInstr.op == OP_DEBUG_BRK) |=> // see RULE4
    resp.cause == EXC_DEBUG_BRK && resp.debugExc && resp.delaySlot && resp.retPc == $past(state_reg.q.pc))
    else $error("debug breakpoint after extended op mis-reported");

  a_dbl_align: assert property ((pairStage && dblMisalign) |=> // see RULE10
    resp.cause == EXC_ADDR_ERR && resp.delaySlot && resp.retPc == $past(state_reg.q.pc))
    else $error("double width misalignment not faulted");

  a_lowest_addr: assert property ((pairStage && notLowest) |=> // see RULE20
    resp.cause == EXC_ADDR_ERR && resp.delaySlot && resp.priorWe)
    else $error("plain access not at lowest address not faulted");

  a_pair_align: assert property ((evalPair && (dblMisalign || notLowest)) |=> // see RULE9
    resp.excValid && !resp.memIssue && !resp.storeCommit)
    else $error("unaligned pair was accessed");

  a_single_access: assert property ((resp.memIssue && resp.pairIsLoad) |-> // see RULE18
    resp.memDouble == SINGLE_ACCESS)
    else $error("load pair access width wrong");

  a_write_guard: assert property (resp.wrExtTarget |-> // see RULE15
    resp.memIssue && resp.wrPlainTarget && (!resp.excValid || resp.cause == EXC_SSTEP))
    else $error("target written without pair access");

  a_store_pair: assert property ((evalPair && extIsStore && !bd0Hit && !pairStage) |=> // see RULE13
    resp.storeCancel && !resp.storeCommit && resp.retPc == $past(state_reg.q.pc) &&
    linkValidFlag == $past(state_reg.linkValid))
    else $error("store pair fault handled wrongly");

  a_mix_fail: assert property ((evalPair && extIsStore && // see RULE17
    isDwordOp(state_reg.linkOp) != isDwordOp(state_reg.q.extInstr.op)) |=> !resp.storeCommit)
    else $error("mismatched width store committed");

  a_trap_fail: assert property ((evalPair && extIsStore && !state_reg.linkValid) |=> // see RULE19
    !resp.storeCommit)
    else $error("store committed without link");

  a_commit_link: assert property (resp.storeCommit |-> // see RULE19
    !linkValidFlag && $past(state_reg.linkValid))
    else $error("commit did not consume link");

  a_ready_eval: assert property ((state_reg.st == ST_EVAL) |-> // see RULE22
    !reqReady && !resp.valid)
    else $error("ready or result during evaluation");

  a_eval_once: assert property ((state_reg.st == ST_EVAL) |=> // see RULE22
    state_reg.st == ST_IDLE && reqReady && resp.valid)
    else $error("evaluation not finished in one cycle");

  a_take_eval: assert property ((state_reg.st == ST_IDLE && reqValid) |=> // see RULE22
    state_reg.st == ST_EVAL && !reqReady)
    else $error("request not taken when idle");

  a_sstep_clean: assert property ((resp.cause == EXC_SSTEP) |-> // see RULE12
    resp.excValid && !resp.storeCancel && !resp.priorWe)
    else $error("single step cancelled the pair");

  a_sstep_pair: assert property ((pairStage && state_reg.q.singleStep && // see RULE12
    !dblMisalign && !notLowest) |=> resp.cause == EXC_SSTEP && resp.retPc == $past(state_reg.q.pc))
    else $error("single step not reported at extended op");

  a_cause_valid: assert property (resp.valid |-> // see RULE11
    resp.excValid == (resp.cause != EXC_NONE))
    else $error("exception flag and cause disagree");

  a_idle_quiet: assert property (!resp.valid |-> // see RULE22
    !resp.excValid && !resp.memIssue && !resp.storeCommit && !resp.storeCancel)
    else $error("result fields outside result cycle");

  a_ext_alone: assert property ((evalPair && !inSlot && state_reg.q.extAloneFault) |=> // see RULE11
    resp.cause == EXC_EXT_ALONE && !resp.delaySlot && resp.retPc == $past(state_reg.q.pc))
    else $error("extended-alone fault mis-reported");

  a_intr_flag: assert property ((evalPair && !inSlot && state_reg.q.interruptPending) |=> // see RULE13
    resp.excValid && !resp.delaySlot && resp.retPc == $past(state_reg.q.pc))
    else $error("interrupt on pair mis-reported");

  a_load_link: assert property ((evalPair && extIsLoad && bd0Hit) |=> // see RULE21
    !linkValidFlag && !resp.memIssue)
    else $error("load pair fault left link set");

  a_load_ok: assert property ((pairStage && extIsLoad && !dblMisalign && !notLowest) |=> // see RULE22
    resp.memIssue && resp.wrExtTarget && resp.wrPlainTarget && linkValidFlag)
    else $error("clean load pair not performed");

  a_slot_quiet: assert property ((evalPair && inSlot) |=> // see RULE2
    !resp.priorWe && !resp.memIssue)
    else $error("slot fault captured or accessed");

  c_load_ok: cover property (resp.valid && resp.pairIsLoad && !resp.excValid);
  c_store_ok: cover property (resp.valid && resp.storeCommit);
  c_brk: cover property (resp.valid && resp.cause == EXC_BREAK);
  c_slot: cover property (resp.valid && resp.cause == EXC_RSVD_INSTR && !resp.priorWe && resp.delaySlot);
  c_sstep: cover property (resp.valid && resp.cause == EXC_SSTEP);

endmodule : llp_pair_checker

/* tb/llp_stream_model.sv */
// Instruction stream model that offers one pair request at a time
`timescale 1ns/1ps
module llp_stream_model
  import llp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bench side
  input wire logic go,
  input wire llp_req_s reqIn,
  // Checker side
  input wire logic reqReady,
  output logic reqValid,
  output llp_req_s req
);
  llp_req_s nextReq;
  logic dw;
  always_comb begin
    nextReq = reqIn;
    dw = reqIn.extInstr.op == OP_LL_DWORD || reqIn.extInstr.op == OP_SC_DWORD;
    if (reqIn.extVaddr == '0) begin
      nextReq.extVaddr = reqIn.plainVaddr + (dw ? DWORD_BYTES : WORD_BYTES);
    end
  end
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
  // Hold the request until taken, then scramble the released lines
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reqValid <= 1'b0;
    end else if (reqValid && reqReady) begin
      reqValid <= #1 1'b0;
      req <= #1 ~req;
    end else if (go && !reqValid) begin
      reqValid <= #1 1'b1;
      req <= #1 nextReq;
    end
  end
endmodule : llp_stream_model

/* tb/test_linked_pair_checker.sv */
// Self-checking bench for the linked pair checker
`timescale 1ns/1ps
module test_linked_pair_checker
  import llp_pkg::*;
;
  localparam logic [63:0] A = 64'h0000_0000_0000_0100;
  localparam logic [63:0] PC = 64'h0000_0000_0000_1000;
  logic ref_clk, resetn, go, reqValid, reqReady, linkValidFlag;
  llp_req_s reqIn, req, q;
  llp_resp_s resp, r;
  int error_cnt, check_count, i;
  llp_op_e lds[3], sts[3];

  llp_pair_checker #(.SINGLE_ACCESS(1'b1)) llp_pair_checker_inst (.ref_clk(ref_clk), .resetn(resetn),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .resp(resp), .linkValidFlag(linkValidFlag));
  llp_stream_model llp_stream_model_inst (.ref_clk(ref_clk), .resetn(resetn), .go(go), .reqIn(reqIn),
    .reqReady(reqReady), .reqValid(reqValid), .req(req));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  function automatic llp_req_s mk(input llp_op_e eo, input llp_op_e no, input logic [63:0] a);
    llp_req_s x;
    x = '0;
    x.pc = PC;
    x.branchPc = 64'h0000_0000_0000_0ffc;
    x.extInstr = '{isExt: 1'b1, op: eo, base: 5'h04, target: 5'h08, word: 32'h1234_5678};
    x.nextInstr = '{isExt: 1'b0, op: no, base: 5'h04, target: 5'h09, word: 32'h0000_0abc};
    x.plainVaddr = a;
    x.plainPaddr = a;
    return x;
  endfunction : mk

  // Offer one request and wait for its answer
  task automatic send(input llp_req_s x);
    int n;
    n = 0;
    reqIn = x;
    go = 1'b1;
    @(posedge ref_clk);
    #1 go = 1'b0;
    while (resp.valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("resp.valid", resp.valid, 1'b1);
    r = resp;
  endtask : send

  task automatic exc(input logic [3:0] c, input logic ds, input logic pw, input logic [63:0] ret = PC);
    chk("excValid", r.excValid, 1'b1);
    chk("cause", r.cause, c);
    chk("retPc", r.retPc, ret);
    chk("delaySlot", r.delaySlot, ds);
    chk("priorWe", r.priorWe, pw);
    if (pw) chk("priorInstr", r.priorInstr, 32'h1234_5678);
  endtask : exc

  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    go = 1'b0;
    reqIn = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    #1 resetn = 1'b1;
    chk("reqReady", reqReady, 1'b1);
    chk("link", linkValidFlag, 1'b0);
    lds = '{OP_LL_WORD, OP_LL_DWORD, OP_LL_WORD_ALT};
    sts = '{OP_SC_WORD, OP_SC_DWORD, OP_SC_WORD_ALT};
    for (i = 0; i < 3; i++) begin
      send(mk(lds[i], lds[i], A));
      chk("ldExc", r.excValid, 1'b0);
      chk("pairLoad", {r.pairIsLoad, r.pairIsStore}, 2'h2);
      chk("memDouble", {r.memIssue, r.memDouble}, 2'h3);
      chk("wrBoth", r.wrExtTarget & r.wrPlainTarget, 1'b1);
      chk("linkSet", linkValidFlag, 1'b1);
      send(mk(sts[i], sts[i], A));
      chk("commit", r.storeCommit, 1'b1);
      chk("pairStore", {r.pairIsLoad, r.pairIsStore}, 2'h1);
      chk("linkClr", linkValidFlag, 1'b0);
    end
    $display("Test matching pairs done");
    send(mk(OP_LL_WORD, OP_LL_WORD, A));
    send(mk(OP_LL_WORD, OP_SC_WORD, A));
    exc(EXC_RSVD_INSTR, 1'b1, 1'b1);
    chk("linkFault", linkValidFlag, 1'b0);
    chk("noAccess", {r.memIssue, r.wrExtTarget, r.wrPlainTarget}, 3'h0);
    q = mk(OP_LL_WORD, OP_LL_WORD, A);
    q.pc = r.retPc;
    send(q);
    chk("resume", linkValidFlag, 1'b1);
    send(mk(OP_LL_WORD, OP_BREAK, A));
    exc(EXC_BREAK, 1'b1, 1'b1);
    send(mk(OP_SC_WORD, OP_DEBUG_BRK, A));
    exc(EXC_DEBUG_BRK, 1'b1, 1'b1);
    chk("debugExc", r.debugExc, 1'b1);
    q = mk(OP_LL_DWORD, OP_LL_DWORD, A);
    q.nextInstr.base = 5'h05;
    send(q);
    exc(EXC_RSVD_INSTR, 1'b1, 1'b1);
    for (i = 0; i < 2; i++) begin
      q = mk(OP_SC_WORD, OP_SC_WORD, A);
      q.inDelaySlot = (i == 0);
      q.inForbiddenSlot = (i == 1);
      send(q);
      exc(EXC_RSVD_INSTR, 1'b1, 1'b0, 64'h0000_0000_0000_0ffc);
    end
    q = mk(OP_LL_WORD_ALT, OP_SC_WORD, A);
    q.extInstr.target = 5'h04;
    send(q);
    exc(EXC_RSVD_INSTR, 1'b0, 1'b0);
    q = mk(OP_LL_WORD, OP_BREAK, A);
    q.extAloneFault = 1'b1;
    send(q);
    exc(EXC_EXT_ALONE, 1'b0, 1'b0);
    $display("Test pair faults done");
    send(mk(OP_LL_WORD, OP_LL_WORD, A + 64'h1));
    exc(EXC_ADDR_ERR, 1'b0, 1'b0);
    send(mk(OP_SC_DWORD, OP_SC_DWORD, A + 64'h4));
    exc(EXC_ADDR_ERR, 1'b0, 1'b0);
    send(mk(OP_LL_WORD, OP_LL_WORD, A + 64'h4));
    exc(EXC_ADDR_ERR, 1'b1, 1'b1);
    send(mk(OP_LL_DWORD, OP_LL_DWORD, A + 64'h8));
    exc(EXC_ADDR_ERR, 1'b1, 1'b1);
    q = mk(OP_SC_WORD, OP_SC_WORD, A);
    q.plainPaddr = 64'h0000_0000_0000_0204;
    send(q);
    exc(EXC_ADDR_ERR, 1'b1, 1'b1);
    q = mk(OP_LL_WORD, OP_LL_WORD, A);
    q.extVaddr = 64'h0000_0000_0000_00fc;
    send(q);
    exc(EXC_ADDR_ERR, 1'b1, 1'b1);
    $display("Test alignment done");
    q = mk(OP_LL_WORD, OP_LL_WORD, A);
    q.singleStep = 1'b1;
    send(q);
    exc(EXC_SSTEP, 1'b0, 1'b0);
    chk("stepPair", {r.debugExc, r.memIssue}, 2'h3);
    send(mk(OP_SC_WORD, OP_BREAK, A));
    chk("cancel", {r.storeCancel, r.storeCommit, linkValidFlag}, 3'h5);
    q = mk(OP_SC_WORD, OP_SC_WORD, A);
    q.interruptPending = 1'b1;
    send(q);
    exc(EXC_INTR, 1'b0, 1'b0);
    chk("intCancel", {r.storeCancel, linkValidFlag}, 2'h3);
    q.interruptPending = 1'b0;
    q.pc = r.retPc;
    send(q);
    chk("retry", r.storeCommit, 1'b1);
    send(mk(OP_LL_WORD, OP_LL_WORD, A));
    send(mk(OP_SC_DWORD, OP_SC_DWORD, A));
    chk("mixType", r.storeCommit, 1'b0);
    send(mk(OP_LL_WORD, OP_LL_WORD, A));
    send(mk(OP_LL_WORD, OP_BREAK, A));
    send(mk(OP_SC_WORD, OP_SC_WORD, A));
    chk("trapFail", r.storeCommit, 1'b0);
    $display("Test link effects done");
    stop_test();
  end
endmodule : test_linked_pair_checker
